// ==== design/msj_top.sv ====
// motor state classifier and jam stage with an axi4-lite register slave
// assumes phase magnitudes come from logic on clk; panel_key is an async pin
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module msj_top
  import msj_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int FORCE_LEN = FORCE_TICKS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] phase_a_current,
  input wire logic [15:0] phase_b_current,
  input wire logic [15:0] phase_c_current,
  input wire logic panel_key,
  output logic motor_stopped,
  output logic motor_starting,
  output logic motor_running,
  output logic jam_start,
  output logic jam_trip
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // a x b / 100, kept to 16 bits (settings are percentages)
  function automatic logic [15:0] pct_of(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = (32'(a) * 32'(b)) / 32'd100;
    return p[15:0];
  endfunction

  // ---------------------------------------------------------------
  // processing tick
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick_q;

  // one-cycle tick pulse every TICK_LEN clocks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_LEN - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers and axi4-lite slave
  // ---------------------------------------------------------------
  msj_cfg_s cfg_q;
  logic force_q;
  logic [31:0] force_tmr_q;
  logic key_s1_q, key_s2_q, key_s3_q;
  logic key_edge;
  logic wr_go, rd_go, wr_hit_ctrl;
  logic [31:0] wr_word, rd_word;
  logic rd_ok;
  msj_state_e st_q;
  logic stg_start_q, stg_trip_q;
  logic [15:0] start_cnt_q, trip_cnt_q, fault_max_q, avg_w, thr_w, thr_amps_w;
  logic [6:0] pct_q;

  // both write channels are taken together, so order between them never matters
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign wr_hit_ctrl = wr_go && (s_axi_awaddr == REG_CTRL);

  // current word of the addressed writable register, merged with the strobes
  always_comb begin
    case (s_axi_awaddr)
      REG_CTRL: wr_word = {27'h0, cfg_q.force_trip, cfg_q.force_start, force_q, cfg_q.enable,
                           cfg_q.definite_characteristic};
      REG_START_DETECT: wr_word = {16'h0, cfg_q.start_detect};
      REG_NOM_START: wr_word = {16'h0, cfg_q.nominal_start_current};
      REG_PICKUP: wr_word = {16'h0, cfg_q.pickup_pct};
      REG_OP_TIME: wr_word = {16'h0, cfg_q.op_time};
      REG_INV_COEFF: wr_word = {16'h0, cfg_q.inv_coeff};
      REG_MOTOR_AMPS: wr_word = {16'h0, cfg_q.motor_amps};
      default: wr_word = 32'h0000_0000;
    endcase
    wr_word = merge_strb(wr_word, s_axi_wdata, s_axi_wstrb);
  end

  // settings writes; unmapped or read-only targets are dropped with slverr
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q.definite_characteristic <= 1'b1;
      cfg_q.enable <= 1'b1;
      cfg_q.force_start <= 1'b0;
      cfg_q.force_trip <= 1'b0;
      cfg_q.start_detect <= START_DET_RST;
      cfg_q.nominal_start_current <= NOM_START_RST;
      cfg_q.pickup_pct <= PICKUP_RST;
      cfg_q.op_time <= OP_TIME_RST;
      cfg_q.inv_coeff <= INV_COEFF_RST;
      cfg_q.motor_amps <= MOTOR_AMPS_RST;
    end else if (wr_go) begin
      case (s_axi_awaddr)
        REG_CTRL: begin
          cfg_q.definite_characteristic <= wr_word[CTRL_DEF_BIT];
          cfg_q.enable <= wr_word[CTRL_ENA_BIT];
          cfg_q.force_start <= wr_word[CTRL_FSTART_BIT];
          cfg_q.force_trip <= wr_word[CTRL_FTRIP_BIT];
        end
        REG_START_DETECT: cfg_q.start_detect <= wr_word[15:0];
        REG_NOM_START: cfg_q.nominal_start_current <= wr_word[15:0];
        REG_PICKUP: cfg_q.pickup_pct <= wr_word[15:0];
        REG_OP_TIME: cfg_q.op_time <= wr_word[15:0];
        REG_INV_COEFF: cfg_q.inv_coeff <= wr_word[15:0];
        REG_MOTOR_AMPS: cfg_q.motor_amps <= wr_word[15:0];
        default: ;
      endcase
    end
  end

  // write response one cycle after the take
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr <= REG_MOTOR_AMPS && s_axi_awaddr[1:0] == 2'b00) ?
                     RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read decode
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      REG_CTRL: rd_word = {27'h0, cfg_q.force_trip, cfg_q.force_start, force_q, cfg_q.enable,
                           cfg_q.definite_characteristic};
      REG_START_DETECT: rd_word = {16'h0, cfg_q.start_detect};
      REG_NOM_START: rd_word = {16'h0, cfg_q.nominal_start_current};
      REG_PICKUP: rd_word = {16'h0, cfg_q.pickup_pct};
      REG_OP_TIME: rd_word = {16'h0, cfg_q.op_time};
      REG_INV_COEFF: rd_word = {16'h0, cfg_q.inv_coeff};
      REG_MOTOR_AMPS: rd_word = {16'h0, cfg_q.motor_amps};
      REG_STATUS: rd_word = {27'h0, force_q, stg_trip_q, stg_start_q, st_q};
      REG_COUNTS: rd_word = {trip_cnt_q, start_cnt_q};
      REG_AVG: rd_word = {16'h0, avg_w};
      REG_RECORD: rd_word = {9'h0, pct_q, fault_max_q};
      REG_PICKUP_AMPS: rd_word = {16'h0, thr_amps_w};
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // read data registered one cycle after the take
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // test forcing flag
  // ---------------------------------------------------------------
  // key pin is asynchronous: two flops, then an edge detector on the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      key_s3_q <= 1'b0;
    end else begin
      key_s1_q <= panel_key;
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
    end
  end
  assign key_edge = key_s2_q && !key_s3_q;

  // software set beats the timeout clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_q <= 1'b0;
      force_tmr_q <= 32'h0000_0000;
    end else if (wr_hit_ctrl && s_axi_wstrb[0]) begin
      force_q <= wr_word[CTRL_FORCE_BIT];
      force_tmr_q <= 32'h0000_0000;
    end else if (!force_q || key_edge) begin
      force_tmr_q <= 32'h0000_0000;
    end else if (tick_q) begin
      if (force_tmr_q >= 32'(FORCE_LEN - 1)) begin
        force_q <= 1'b0;
      end
      force_tmr_q <= force_tmr_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // motor state classifier
  // ---------------------------------------------------------------
  logic [17:0] sum_w;
  logic [15:0] dwell_q, rise_q;
  logic dwell_ok_w, low_w, band_w;

  assign sum_w = 18'(phase_a_current) + 18'(phase_b_current) + 18'(phase_c_current);
  assign avg_w = 16'(sum_w / 18'd3);
  assign low_w = avg_w < STOP_PCT;
  assign band_w = (avg_w >= RUN_LO_PCT) && (avg_w <= RUN_HI_PCT);
  assign dwell_ok_w = dwell_q >= 16'(DWELL_TICKS);

  // dwell only counts while current is really low; rise window times the climb
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= MS_STOPPED;
      dwell_q <= 16'h0000;
      rise_q <= 16'h0000;
    end else if (low_w) begin
      st_q <= MS_STOPPED;
      rise_q <= 16'h0000;
      if (tick_q && !dwell_ok_w) begin
        dwell_q <= dwell_q + 16'h0001;
      end
    end else begin
      case (st_q)
        MS_STOPPED: begin
          if (tick_q && rise_q < 16'(RISE_TICKS)) begin
            rise_q <= rise_q + 16'h0001;
          end
          if (dwell_ok_w && rise_q < 16'(RISE_TICKS) && avg_w > cfg_q.start_detect) begin
            st_q <= MS_STARTING;
          end else if (band_w && (rise_q >= 16'(RISE_TICKS) || !dwell_ok_w)) begin
            st_q <= MS_RUNNING;
          end
        end
        MS_STARTING: begin
          dwell_q <= 16'h0000;
          if (band_w) begin
            st_q <= MS_RUNNING;
          end
        end
        MS_RUNNING: dwell_q <= 16'h0000;
        default: st_q <= MS_STOPPED;
      endcase
    end
  end

  // flags for tripping, indication and blocking elsewhere
  assign motor_stopped = st_q == MS_STOPPED;
  assign motor_starting = st_q == MS_STARTING;
  assign motor_running = st_q == MS_RUNNING;

  // ---------------------------------------------------------------
  // jam stage
  // ---------------------------------------------------------------
  logic pick_w, trip_w;
  logic [31:0] sq_w;
  logic [47:0] acc_q, limit_w;

  assign thr_w = pct_of(cfg_q.pickup_pct, cfg_q.nominal_start_current);
  assign thr_amps_w = pct_of(thr_w, cfg_q.motor_amps);
  assign pick_w = (avg_w > thr_w) && cfg_q.enable && (st_q != MS_STARTING);
  assign sq_w = 32'(avg_w) * 32'(avg_w);
  // inverse: weighting each tick by I^2 reaches Ist^2*k after (Ist/I)^2*k ticks, no divider
  assign limit_w = cfg_q.definite_characteristic ? 48'(cfg_q.op_time) :
                   48'(cfg_q.nominal_start_current) * 48'(cfg_q.nominal_start_current) *
                   48'(cfg_q.inv_coeff);
  assign trip_w = pick_w && (acc_q >= limit_w);

  // operate delay accumulation, cleared on release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= 48'h0;
      stg_start_q <= 1'b0;
      stg_trip_q <= 1'b0;
    end else begin
      stg_start_q <= pick_w;
      stg_trip_q <= trip_w;
      if (!pick_w) begin
        acc_q <= 48'h0;
      end else if (tick_q && !trip_w) begin
        acc_q <= acc_q + (cfg_q.definite_characteristic ? 48'h1 : 48'(sq_w));
      end
    end
  end

  // cumulative event counters, wrap at 16 bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_cnt_q <= 16'h0000;
      trip_cnt_q <= 16'h0000;
    end else begin
      if (pick_w && !stg_start_q) begin
        start_cnt_q <= start_cnt_q + 16'h0001;
      end
      if (trip_w && !stg_trip_q) begin
        trip_cnt_q <= trip_cnt_q + 16'h0001;
      end
    end
  end

  // event record: steps the percent one per clock so it settles long before a tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_max_q <= 16'h0000;
      pct_q <= 7'h00;
    end else if (pick_w && !stg_start_q) begin
      fault_max_q <= avg_w;
      pct_q <= 7'h00;
    end else if (stg_start_q) begin
      if (avg_w > fault_max_q) begin
        fault_max_q <= avg_w;
      end
      if (trip_w) begin
        pct_q <= PCT_FULL;
      end else if (pct_q < PCT_FULL - 7'h01 &&
                   56'(acc_q) * 56'd100 >= 56'(limit_w) * 56'(pct_q + 7'h01)) begin
        pct_q <= pct_q + 7'h01;
      end
    end
  end

  // force overrides the stage outputs for testing
  assign jam_start = force_q ? cfg_q.force_start : stg_start_q;
  assign jam_trip = force_q ? cfg_q.force_trip : stg_trip_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_enter_start;
    (st_q == MS_STOPPED) ##1 (st_q == MS_STARTING);
  endsequence

  property p_stop_low;
    low_w |=> (st_q == MS_STOPPED);
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("low current not stopped");

  property p_dwell;
    s_enter_start |-> $past(dwell_ok_w);
  endproperty
  a_dwell: assert property (p_dwell) else $error("start without dwell");

  property p_rise;
    s_enter_start |-> ($past(rise_q) < 16'(RISE_TICKS));
  endproperty
  a_rise: assert property (p_rise) else $error("start after rise window");

  property p_hold_start;
    (st_q == MS_STARTING && !low_w && !band_w) |=> (st_q == MS_STARTING);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("starting left early");

  property p_run;
    (st_q == MS_STARTING && band_w && !low_w) |=> (st_q == MS_RUNNING);
  endproperty
  a_run: assert property (p_run) else $error("running not entered");

  property p_release;
    (!pick_w) |=> (!stg_start_q && !stg_trip_q && acc_q == 48'h0);
  endproperty
  a_release: assert property (p_release) else $error("stage did not release");

  property p_block;
    (st_q == MS_STARTING) |=> !stg_start_q;
  endproperty
  a_block: assert property (p_block) else $error("jam active while starting");

  property p_dt_trip;
    (pick_w && cfg_q.definite_characteristic && acc_q >= 48'(cfg_q.op_time)) |=> stg_trip_q;
  endproperty
  a_dt_trip: assert property (p_dt_trip) else $error("definite trip missed");

  property p_inv_acc;
    (pick_w && tick_q && !trip_w && !cfg_q.definite_characteristic) ##1 pick_w |->
      (acc_q == $past(acc_q) + 48'($past(sq_w)));
  endproperty
  a_inv_acc: assert property (p_inv_acc) else $error("inverse weighting wrong");

  property p_count;
    $rose(stg_start_q) |-> (start_cnt_q == $past(start_cnt_q) + 16'h0001);
  endproperty
  a_count: assert property (p_count) else $error("start count missed");

  property p_force;
    force_q |-> (jam_start == cfg_q.force_start && jam_trip == cfg_q.force_trip);
  endproperty
  a_force: assert property (p_force) else $error("force not applied");

  property p_trip_pct;
    $rose(stg_trip_q) |=> (pct_q == PCT_FULL);
  endproperty
  a_trip_pct: assert property (p_trip_pct) else $error("trip not recorded full");

endmodule

// ==== design/msj_pkg.sv ====
// package for the motor state classifier and jam (locked rotor) stage
// assumes one 20 MHz clock; currents arrive in percent of motor nominal current
package msj_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the axi4-lite slave)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START_DETECT = 8'h04;
  localparam logic [7:0] REG_NOM_START = 8'h08;
  localparam logic [7:0] REG_PICKUP = 8'h0c;
  localparam logic [7:0] REG_OP_TIME = 8'h10;
  localparam logic [7:0] REG_INV_COEFF = 8'h14;
  localparam logic [7:0] REG_MOTOR_AMPS = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_COUNTS = 8'h20;
  localparam logic [7:0] REG_AVG = 8'h24;
  localparam logic [7:0] REG_RECORD = 8'h28;
  localparam logic [7:0] REG_PICKUP_AMPS = 8'h2c;

  // control register fields
  localparam int CTRL_DEF_BIT = 0;
  localparam int CTRL_ENA_BIT = 1;
  localparam int CTRL_FORCE_BIT = 2;
  localparam int CTRL_FSTART_BIT = 3;
  localparam int CTRL_FTRIP_BIT = 4;

  // reset values
  localparam logic [15:0] START_DET_RST = 16'h0258;  // 6.00 x nominal
  localparam logic [15:0] NOM_START_RST = 16'h0258;  // 6.00 x nominal
  localparam logic [15:0] PICKUP_RST = 16'h0032;     // 50 % of start current
  localparam logic [15:0] OP_TIME_RST = 16'h03e8;    // ticks
  localparam logic [15:0] INV_COEFF_RST = 16'h03e8;  // ticks
  localparam logic [15:0] MOTOR_AMPS_RST = 16'h0064; // primary amperes

  // current levels in percent of motor nominal current, then PCT_FULL, the full-scale operate percent of the event record
  localparam logic [15:0] STOP_PCT = 16'h000a;
  localparam logic [15:0] RUN_LO_PCT = 16'h0014;
  localparam logic [15:0] RUN_HI_PCT = 16'h0078;
  localparam logic [6:0] PCT_FULL = 7'h64;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL_MS = 500;
  localparam int RISE_MS = 200;
  localparam int FORCE_MIN = 5;
  localparam int DWELL_TICKS = (DWELL_MS * 1000000 + TICK_NS - 1) / TICK_NS;
  localparam int RISE_TICKS = (RISE_MS * 1000000) / TICK_NS;
  localparam int FORCE_TICKS = (FORCE_MIN * 60 * 1000) / (TICK_NS / 1000000);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MS_STOPPED = 2'b00,
    MS_STARTING = 2'b01,
    MS_RUNNING = 2'b10
  } msj_state_e;

  // settings that software writes
  typedef struct packed {
    logic definite_characteristic;
    logic enable;
    logic force_start;
    logic force_trip;
    logic [15:0] start_detect;
    logic [15:0] nominal_start_current;
    logic [15:0] pickup_pct;
    logic [15:0] op_time;
    logic [15:0] inv_coeff;
    logic [15:0] motor_amps;
  } msj_cfg_s;

endpackage

// ==== tb/msj_testbench.sv ====
// self-checking bench for the motor state classifier and jam stage
// assumes msj_top with shortened tick and force lengths; bench drives every input
`timescale 1ns/10ps
module testbench;
  import msj_pkg::*;
  // ---------------------------------------------------------------
  // signals and design instance
  // ---------------------------------------------------------------
  localparam int TL = 10;
  localparam int FL = 20;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, panel_key = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [15:0] phase_a_current = 16'h0, phase_b_current = 16'h0, phase_c_current = 16'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic motor_stopped, motor_starting, motor_running, jam_start, jam_trip, st;
  int fail_count = 0, check_count = 0, i;
  msj_top #(.TICK_LEN(TL), .FORCE_LEN(FL)) i_dut (.clk, .resetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .phase_a_current, .phase_b_current, .phase_c_current, .panel_key,
    .motor_stopped, .motor_starting, .motor_running, .jam_start, .jam_trip);
  // 20 MHz clock
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // bus, stimulus and compare tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // address and data offered together, response awaited with bready held
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge clk); while (s_axi_awready !== 1'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task cur(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    phase_a_current <= a;
    phase_b_current <= b;
    phase_c_current <= c;
  endtask
  // cycles from a step to current c until trip, then back to a running load
  task jam_time(input logic [15:0] c);
    cur(c, c, c);
    for (i = 0; i < 400 && jam_trip !== 1'h1; i++) @(posedge clk);
    cur(16'h32, 16'h32, 16'h32);
    cyc(3);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    cyc(20);
    resetn <= 1'h1;
    @(posedge clk);
    chk(motor_stopped, 32'h1);
    rd(REG_START_DETECT);
    chk(rv, 32'h258);
    wr(REG_START_DETECT, 32'h2bc);
    chk(rr, RESP_OKAY);
    rd(REG_START_DETECT);
    chk(rv, 32'h2bc);
    wr(REG_START_DETECT, 32'h258);
    rd(8'h3c);
    chk(rr, RESP_SLVERR);
    // status is read-only: the write is refused and nothing changes
    wr(REG_STATUS, 32'h0);
    chk(rr, RESP_SLVERR);
    $display("test settings done");
    // soft start: band current below start detection, no starting state seen
    st = 1'h0;
    cur(16'h32, 16'h32, 16'h32);
    for (i = 0; i < 2500 && motor_running !== 1'h1; i++) begin
      @(posedge clk);
      st = st | motor_starting;
    end
    chk(motor_running, 32'h1);
    chk(st, 32'h0);
    $display("test soft start done");
    // definite time, pickup 300 % of nominal; mean sits on the threshold first
    wr(REG_OP_TIME, 32'h5);
    cur(16'h12c, 16'h12c, 16'h12d);
    cyc(5);
    chk(jam_start, 32'h0);
    cur(16'h12c, 16'h12c, 16'h130);
    cyc(2);
    chk(jam_start, 32'h1);
    cyc(28);
    cur(16'h32, 16'h32, 16'h32);
    cyc(2);
    chk(jam_start, 32'h0);
    // n ticks of delay trip between (n-1)*TL+3 and n*TL+2 edges, by tick phase
    jam_time(16'h190);
    chk(i >= 4*TL+3 && i <= 5*TL+2, 32'h1);
    chk(jam_trip, 32'h0);
    rd(REG_COUNTS);
    chk(rv, 32'h0001_0002);
    rd(REG_RECORD);
    chk(rv[22:16], 32'h64);
    chk(rv[15:0], 32'h190);
    rd(REG_PICKUP_AMPS);
    chk(rv, 32'h12c);
    $display("test definite done");
    // inverse time with k of 4 ticks: full delay at 600 %, a quarter at 1200 %
    wr(REG_CTRL, 32'h2);
    wr(REG_INV_COEFF, 32'h4);
    jam_time(16'h258);
    chk(i >= 3*TL+3 && i <= 4*TL+2, 32'h1);
    jam_time(16'h4b0);
    chk(i >= 3 && i <= TL+2, 32'h1);
    wr(REG_CTRL, 32'h3);
    $display("test inverse done");
    // short stop must not allow a start; a long one does, and blocks the stage
    cur(16'h0, 16'h0, 16'h0);
    cyc(2);
    chk(motor_stopped, 32'h1);
    cyc(20);
    cur(16'h2bc, 16'h2bc, 16'h2bc);
    cyc(3);
    chk(motor_starting, 32'h0);
    cur(16'h0, 16'h0, 16'h0);
    cyc(5200);
    cur(16'h2bc, 16'h2bc, 16'h2bc);
    cyc(3);
    chk(motor_starting, 32'h1);
    cyc(100);
    chk(motor_starting, 32'h1);
    chk({jam_start, jam_trip}, 32'h0);
    cur(16'h32, 16'h32, 16'h32);
    for (i = 0; i < 50 && motor_running !== 1'h1; i++) @(posedge clk);
    chk(motor_running, 32'h1);
    $display("test starting done");
    // force flag: key press restarts the timeout, then it clears by itself
    wr(REG_CTRL, 32'h17);
    cyc(2);
    chk(jam_trip, 32'h1);
    cyc(100);
    panel_key <= 1'h1;
    cyc(3);
    panel_key <= 1'h0;
    cyc(150);
    chk(jam_trip, 32'h1);
    cyc(100);
    chk(jam_trip, 32'h0);
    rd(REG_STATUS);
    chk(rv[4], 32'h0);
    $display("test force done");
    stop_test();
  end
  // watchdog well beyond the roughly 6000 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule
